// ### include/supervisor_regs.svh
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

`define SUP_ADDR_W 8
`define SUP_CTRL_OFS 8'h00
`define SUP_STATUS_OFS 8'h04
`define SUP_MASK_OFS 8'h08
`define SUP_LIVE_OFS 8'h0C

`define SUP_CTRL_RST 7'h00
`define SUP_EVT_RST 5'h00
`define SUP_MASK_RST 5'h00
`define SUP_GAIN_RST 8'h02

`define SUP_CLK_MHZ 250
`define SUP_FAIL_NS 500000
`define SUP_OC_DEB_NS 135000
`define SUP_CM_DEB_NS 40000
`define SUP_RECOVER_NS 4680000
`define SUP_STEP_NS 10000
`define SUP_DECAY1_MS 30
`define SUP_DECAY2_MS 100
`define SUP_DECAY3_MS 300
`define SUP_SWAP0_NS 10000
`define SUP_SWAP1_NS 50000
`define SUP_SWAP2_NS 100000
`define SUP_SWAP3_NS 200000
`define SUP_GAIN_MIN 2
`define SUP_GAIN_MAX 120

`define SUP_NS_TO_CYC(t) ((t) * `SUP_CLK_MHZ / 1000)
`define SUP_MS_TO_CYC(t) ((t) * `SUP_CLK_MHZ * 1000)

`endif

// ### include/supervisor_pkg.sv
package supervisor_pkg;

  typedef enum logic [0:0] {
    ST_DRIVE = 1'b0,
    ST_OFF = 1'b1
  } out_state_e;

  typedef struct packed {
    logic target_3v0;
    logic boost;
    logic [1:0] decay_sel;
    logic [1:0] swap_sel;
    logic swap_en;
  } ctrl_s;

  typedef struct packed {
    logic recovered;
    logic offset_err;
    logic coil_err;
    logic cm_trip;
    logic oc_trip;
  } evt_s;

  typedef struct packed {
    logic [3:0] oc;
    logic [3:0] cm;
    logic coil_open;
    logic coil_gnd;
    logic coil_vdd;
    logic offset;
    logic amp_low;
    logic amp_high;
    logic supply_5v;
    logic addr_sel;
  } pins_s;

endpackage

// ### logic/sensor_diag_agc_supervisor.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "supervisor_regs.svh"
// Operation
// - Any detected diagnostic error drives the alarm pin within 500 us.
// - Overcurrent lasting 135 us tristates all four analog outputs.
// - Overcurrent shorter than its debounce time leaves outputs driven.
// - Common-mode fault lasting 40 us tristates all four outputs.
// - Common-mode fault shorter than its debounce time is ignored.
// - Outputs return 4.61 to 4.75 ms after an overcurrent switch-off.
// - Outputs return after the same 4.68 ms after common-mode switch-off.
// - Coil error flag follows open coil or input shorts, clears after.
// - Offset alarm flag follows the output offset comparator.
// - Gain steps every 10 us; reversal waits 0, 30, 100 or 300 ms.
// - Enabled channel swap toggles every 10, 50, 100 or 200 us.
// - Gain boost bit doubles the gain range to 4 to 240.
// - Target 3.0 Vpp is selectable only in 5 V mode, else 1.8 Vpp.
module sensor_diag_agc_supervisor #(
  parameter int unsigned OC_DEB_CYC = `SUP_NS_TO_CYC(`SUP_OC_DEB_NS),
  parameter int unsigned CM_DEB_CYC = `SUP_NS_TO_CYC(`SUP_CM_DEB_NS),
  parameter int unsigned RECOVER_CYC = `SUP_NS_TO_CYC(`SUP_RECOVER_NS),
  parameter int unsigned DECAY1_CYC = `SUP_MS_TO_CYC(`SUP_DECAY1_MS),
  parameter int unsigned DECAY2_CYC = `SUP_MS_TO_CYC(`SUP_DECAY2_MS),
  parameter int unsigned DECAY3_CYC = `SUP_MS_TO_CYC(`SUP_DECAY3_MS),
  parameter int unsigned SWAP0_CYC = `SUP_NS_TO_CYC(`SUP_SWAP0_NS),
  parameter int unsigned SWAP1_CYC = `SUP_NS_TO_CYC(`SUP_SWAP1_NS),
  parameter int unsigned SWAP2_CYC = `SUP_NS_TO_CYC(`SUP_SWAP2_NS),
  parameter int unsigned SWAP3_CYC = `SUP_NS_TO_CYC(`SUP_SWAP3_NS)
) (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [3:0] OC_FAULT_IN,
  input wire logic [3:0] CM_FAULT_IN,
  input wire logic COIL_OPEN_IN,
  input wire logic COIL_SHORT_GND_IN,
  input wire logic COIL_SHORT_VDD_IN,
  input wire logic OFFSET_ALARM_IN,
  input wire logic AMP_LOW_IN,
  input wire logic AMP_HIGH_IN,
  input wire logic SUPPLY_5V_IN,
  input wire logic ALARM_ADDR_SELECT_PIN_IN,
  output logic ALARM_ADDR_SELECT_PIN_OUT,
  output logic ALARM_ADDR_SELECT_PIN_OE_OUT,
  output logic [3:0] ANALOG_OE_OUT,
  output logic SWAP_OUT,
  output logic [7:0] GAIN_OUT,
  output logic TARGET_3V0_OUT,
  output logic IRQ_OUT
);

  localparam int unsigned STEP_CYC = `SUP_NS_TO_CYC(`SUP_STEP_NS);
  localparam int unsigned FAIL_CYC = `SUP_NS_TO_CYC(`SUP_FAIL_NS);

  if (OC_DEB_CYC < 1 || CM_DEB_CYC < 1 || RECOVER_CYC < 1 ||
      OC_DEB_CYC > FAIL_CYC || CM_DEB_CYC > FAIL_CYC ||
      SWAP0_CYC < 1 || SWAP1_CYC < 1 || SWAP2_CYC < 1 || SWAP3_CYC < 1 ||
      DECAY1_CYC < 1 || DECAY2_CYC < 1 || DECAY3_CYC < 1) begin : g_chk
    $error("Timing parameters out of range.");
  end

  // Every pin input passes two flip-flops before any logic reads it.
  supervisor_pkg::pins_s meta_q;
  supervisor_pkg::pins_s pins_q;
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      meta_q <= '0;
      pins_q <= '0;
    end else begin
      meta_q <= {OC_FAULT_IN, CM_FAULT_IN, COIL_OPEN_IN, COIL_SHORT_GND_IN,
                 COIL_SHORT_VDD_IN, OFFSET_ALARM_IN, AMP_LOW_IN, AMP_HIGH_IN,
                 SUPPLY_5V_IN, ALARM_ADDR_SELECT_PIN_IN};
      pins_q <= meta_q;
    end
  end

  wire logic oc_any = |pins_q.oc;
  wire logic cm_any = |pins_q.cm;

  supervisor_pkg::ctrl_s ctrl_q;
  supervisor_pkg::evt_s sts_q;
  supervisor_pkg::evt_s mask_q;
  supervisor_pkg::evt_s evt;
  supervisor_pkg::out_state_e state_q;
  logic [31:0] oc_cnt_q;
  logic [31:0] cm_cnt_q;
  logic [31:0] rec_cnt_q;
  logic coil_q;
  logic offset_q;
  logic alarm_q;
  logic oc_trip;
  logic cm_trip;
  logic rec_done;

  assign oc_trip = (state_q == supervisor_pkg::ST_DRIVE) && oc_any &&
                   (oc_cnt_q == OC_DEB_CYC - 1);
  assign cm_trip = (state_q == supervisor_pkg::ST_DRIVE) && cm_any &&
                   (cm_cnt_q == CM_DEB_CYC - 1);
  assign rec_done = (state_q == supervisor_pkg::ST_OFF) &&
                    (rec_cnt_q == RECOVER_CYC - 1);

  // A counter only advances through an unbroken fault episode.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      oc_cnt_q <= 32'h00000000;
      cm_cnt_q <= 32'h00000000;
    end else if (state_q == supervisor_pkg::ST_OFF) begin
      oc_cnt_q <= 32'h00000000;
      cm_cnt_q <= 32'h00000000;
    end else begin
      oc_cnt_q <= oc_any ? oc_cnt_q + 32'h00000001 : 32'h00000000;
      cm_cnt_q <= cm_any ? cm_cnt_q + 32'h00000001 : 32'h00000000;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q <= supervisor_pkg::ST_DRIVE;
      rec_cnt_q <= 32'h00000000;
    end else begin
      case (state_q)
        supervisor_pkg::ST_DRIVE: begin
          rec_cnt_q <= 32'h00000000;
          if (oc_trip || cm_trip) begin
            state_q <= supervisor_pkg::ST_OFF;
          end
        end
        supervisor_pkg::ST_OFF: begin
          rec_cnt_q <= rec_cnt_q + 32'h00000001;
          if (rec_done) begin
            state_q <= supervisor_pkg::ST_DRIVE;
          end
        end
        default: begin
          state_q <= supervisor_pkg::ST_DRIVE;
        end
      endcase
    end
  end

  // Outputs stay driven unless a debounced trip moved the machine off.
  assign ANALOG_OE_OUT = {4{state_q == supervisor_pkg::ST_DRIVE}};

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      coil_q <= 1'b0;
      offset_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      coil_q <= pins_q.coil_open | pins_q.coil_gnd | pins_q.coil_vdd;
      offset_q <= pins_q.offset;
      alarm_q <= coil_q | offset_q | oc_trip | cm_trip |
                 (state_q == supervisor_pkg::ST_OFF);
    end
  end

  // The alarm pin is open drain and pulls low while an error stands.
  assign ALARM_ADDR_SELECT_PIN_OUT = 1'b0;
  assign ALARM_ADDR_SELECT_PIN_OE_OUT = alarm_q;

  // Automatic gain control.
  logic [31:0] step_cnt_q;
  logic [31:0] decay_cnt_q;
  logic [31:0] decay_cyc;
  logic dir_up_q;
  logic waiting_q;
  logic [7:0] gain_q;
  wire logic step_tick = (step_cnt_q == STEP_CYC - 1);
  wire logic want = pins_q.amp_low ^ pins_q.amp_high;
  wire logic want_up = pins_q.amp_low;

  always_comb begin
    case (ctrl_q.decay_sel)
      2'h0: decay_cyc = 32'h00000000;
      2'h1: decay_cyc = DECAY1_CYC;
      2'h2: decay_cyc = DECAY2_CYC;
      default: decay_cyc = DECAY3_CYC;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      step_cnt_q <= 32'h00000000;
    end else begin
      step_cnt_q <= step_tick ? 32'h00000000 : step_cnt_q + 32'h00000001;
    end
  end

  // A reversal first waits out the decay time, then steps the new way.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dir_up_q <= 1'b1;
      waiting_q <= 1'b0;
      decay_cnt_q <= 32'h00000000;
      gain_q <= `SUP_GAIN_RST;
    end else if (waiting_q) begin
      if (!want || want_up == dir_up_q) begin
        waiting_q <= 1'b0;
      end else if (decay_cnt_q >= decay_cyc - 32'h00000001) begin
        waiting_q <= 1'b0;
        dir_up_q <= want_up;
      end else begin
        decay_cnt_q <= decay_cnt_q + 32'h00000001;
      end
    end else if (want && want_up != dir_up_q) begin
      if (decay_cyc == 32'h00000000) begin
        dir_up_q <= want_up;
      end else begin
        waiting_q <= 1'b1;
        decay_cnt_q <= 32'h00000000;
      end
    end else if (want && step_tick) begin
      if (want_up && gain_q < 8'(`SUP_GAIN_MAX)) begin
        gain_q <= gain_q + 8'h01;
      end else if (!want_up && gain_q > 8'(`SUP_GAIN_MIN)) begin
        gain_q <= gain_q - 8'h01;
      end
    end
  end

  // Boost doubles the effective gain, so the range becomes 4 to 240.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      GAIN_OUT <= 8'h00;
      TARGET_3V0_OUT <= 1'b0;
    end else begin
      GAIN_OUT <= ctrl_q.boost ? {gain_q[6:0], 1'b0} : gain_q;
      TARGET_3V0_OUT <= ctrl_q.target_3v0 & pins_q.supply_5v;
    end
  end

  // Channel swapping.
  logic [31:0] swap_cnt_q;
  logic [31:0] swap_cyc;
  always_comb begin
    case (ctrl_q.swap_sel)
      2'h0: swap_cyc = SWAP0_CYC;
      2'h1: swap_cyc = SWAP1_CYC;
      2'h2: swap_cyc = SWAP2_CYC;
      default: swap_cyc = SWAP3_CYC;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      swap_cnt_q <= 32'h00000000;
      SWAP_OUT <= 1'b0;
    end else if (!ctrl_q.swap_en) begin
      swap_cnt_q <= 32'h00000000;
      SWAP_OUT <= 1'b0;
    end else if (swap_cnt_q >= swap_cyc - 32'h00000001) begin
      swap_cnt_q <= 32'h00000000;
      SWAP_OUT <= ~SWAP_OUT;
    end else begin
      swap_cnt_q <= swap_cnt_q + 32'h00000001;
    end
  end

  // Event capture for the interrupt; a set in the clear cycle wins.
  logic coil_d1_q;
  logic offset_d1_q;
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      coil_d1_q <= 1'b0;
      offset_d1_q <= 1'b0;
    end else begin
      coil_d1_q <= coil_q;
      offset_d1_q <= offset_q;
    end
  end

  assign evt = '{recovered: rec_done, offset_err: offset_q & ~offset_d1_q,
                 coil_err: coil_q & ~coil_d1_q, cm_trip: cm_trip,
                 oc_trip: oc_trip};

  // APB slave with zero wait states.
  wire logic wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire logic hit = (PADDR_IN == `SUP_CTRL_OFS) ||
                   (PADDR_IN == `SUP_STATUS_OFS) ||
                   (PADDR_IN == `SUP_MASK_OFS) ||
                   (PADDR_IN == `SUP_LIVE_OFS);

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl_q <= `SUP_CTRL_RST;
      mask_q <= `SUP_MASK_RST;
      sts_q <= `SUP_EVT_RST;
    end else begin
      if (wr && PADDR_IN == `SUP_CTRL_OFS) begin
        ctrl_q <= PWDATA_IN[6:0];
      end
      if (wr && PADDR_IN == `SUP_MASK_OFS) begin
        mask_q <= PWDATA_IN[4:0];
      end
      if (wr && PADDR_IN == `SUP_STATUS_OFS) begin
        sts_q <= (sts_q & ~PWDATA_IN[4:0]) | evt;
      end else begin
        sts_q <= sts_q | evt;
      end
    end
  end

  always_comb begin
    PRDATA_OUT = 32'h00000000;
    case (PADDR_IN)
      `SUP_CTRL_OFS: PRDATA_OUT[6:0] = ctrl_q;
      `SUP_STATUS_OFS: PRDATA_OUT[4:0] = sts_q;
      `SUP_MASK_OFS: PRDATA_OUT[4:0] = mask_q;
      `SUP_LIVE_OFS: PRDATA_OUT = {16'h0000, gain_q, 2'h0, pins_q.addr_sel,
                                   SWAP_OUT, alarm_q, offset_q, coil_q,
                                   state_q == supervisor_pkg::ST_OFF};
      default: PRDATA_OUT = 32'h00000000;
    endcase
  end

  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit;
  assign IRQ_OUT = |(sts_q & mask_q);

endmodule

// ### tb/supervisor_sva.sv
`timescale 1ns/1ns
module supervisor_sva #(
  parameter int unsigned OC_DEB_CYC = 20,
  parameter int unsigned CM_DEB_CYC = 8,
  parameter int unsigned RECOVER_CYC = 50
) (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic [3:0] OC_FAULT_IN,
  input wire logic [3:0] CM_FAULT_IN,
  input wire logic COIL_OPEN_IN,
  input wire logic COIL_SHORT_GND_IN,
  input wire logic COIL_SHORT_VDD_IN,
  input wire logic OFFSET_ALARM_IN,
  input wire logic SUPPLY_5V_IN,
  input wire logic ALARM_ADDR_SELECT_PIN_OE_OUT,
  input wire logic [3:0] ANALOG_OE_OUT,
  input wire logic [7:0] GAIN_OUT,
  input wire logic TARGET_3V0_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  int unsigned oc_q, cm_q, off_q;
  logic seen_q;
  wire on = &ANALOG_OE_OUT;
  wire err = COIL_OPEN_IN | COIL_SHORT_GND_IN | COIL_SHORT_VDD_IN
    | OFFSET_ALARM_IN;
  // A standing trip fault also raises the alarm, so it breaks quiet too.
  wire busy = err | (|OC_FAULT_IN) | (|CM_FAULT_IN);
  // Fault runs only count while driven, since faults are ignored when off.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      oc_q <= 0;
      cm_q <= 0;
      off_q <= 0;
      seen_q <= 1'b0;
    end else begin
      oc_q <= (|OC_FAULT_IN && on) ? oc_q + 1 : 0;
      cm_q <= (|CM_FAULT_IN && on) ? cm_q + 1 : 0;
      off_q <= on ? 0 : off_q + 1;
      seen_q <= on && (seen_q || oc_q >= OC_DEB_CYC || cm_q >= CM_DEB_CYC);
    end
  end
  sequence s_quiet;
    !busy && on;
  endsequence
  AST_OE_ALL: assert property (ANALOG_OE_OUT == 4'h0 || on)
    else $error("analog enables differ");
  AST_OC_TRIP: assert property (oc_q == OC_DEB_CYC |-> ##[1:6] !on)
    else $error("overcurrent did not switch off");
  AST_CM_TRIP: assert property (cm_q == CM_DEB_CYC |-> ##[1:6] !on)
    else $error("common mode fault did not switch off");
  AST_DEB_ONLY: assert property ($fell(on) |-> seen_q)
    else $error("switch off without a full fault run");
  AST_RECOVER: assert property ($rose(on) |->
    off_q + 1 >= RECOVER_CYC && off_q <= RECOVER_CYC + 1)
    else $error("recovery interval wrong");
  AST_ALARM: assert property ((err || !on) |->
    ##[0:5] ALARM_ADDR_SELECT_PIN_OE_OUT)
    else $error("alarm late");
  AST_ALARM_CLR: assert property (s_quiet [*8] |=>
    !ALARM_ADDR_SELECT_PIN_OE_OUT)
    else $error("alarm stuck");
  AST_GAIN: assert property ($past(ARST_N_IN) |->
    GAIN_OUT >= 8'h02 && GAIN_OUT <= 8'hF0)
    else $error("gain out of range");
  AST_TARGET: assert property ((!SUPPLY_5V_IN) [*5] |->
    !TARGET_3V0_OUT)
    else $error("high target outside 5 V mode");
endmodule
bind sensor_diag_agc_supervisor supervisor_sva #(.OC_DEB_CYC(OC_DEB_CYC),
  .CM_DEB_CYC(CM_DEB_CYC), .RECOVER_CYC(RECOVER_CYC)) u_sva (
  .CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .OC_FAULT_IN(OC_FAULT_IN),
  .CM_FAULT_IN(CM_FAULT_IN), .COIL_OPEN_IN(COIL_OPEN_IN),
  .COIL_SHORT_GND_IN(COIL_SHORT_GND_IN),
  .COIL_SHORT_VDD_IN(COIL_SHORT_VDD_IN), .OFFSET_ALARM_IN(OFFSET_ALARM_IN),
  .SUPPLY_5V_IN(SUPPLY_5V_IN),
  .ALARM_ADDR_SELECT_PIN_OE_OUT(ALARM_ADDR_SELECT_PIN_OE_OUT),
  .ANALOG_OE_OUT(ANALOG_OE_OUT), .GAIN_OUT(GAIN_OUT),
  .TARGET_3V0_OUT(TARGET_3V0_OUT));

// ### tb/alarm_controller.sv
`timescale 1ns/1ns
module alarm_controller (
  input wire logic pull_oe_in,
  input wire logic pull_val_in,
  input wire logic [3:0] analog_oe_in,
  output logic pin_level_out,
  output logic alarm_out,
  output logic live_out
);
  // The pin carries a pull-up, so a released pin reads high.
  assign pin_level_out = pull_oe_in ? pull_val_in : 1'b1;
  assign alarm_out = !pin_level_out;
  assign live_out = &analog_oe_in;
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
  localparam int OCD = 20;
  localparam int CMD = 8;
  localparam int REC = 50;
  localparam int DCY1 = 10;
  localparam int DCY2 = 20;
  localparam int DCY3 = 30;
  localparam logic [3:0][7:0] SWP = {8'h0A, 8'h08, 8'h06, 8'h04};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [3:0] oc = 4'h0;
  logic [3:0] cm = 4'h0;
  logic [3:0] coil = 4'h0;
  logic low = 1'b0;
  logic high = 1'b0;
  logic s5v = 1'b0;
  logic pready, pslverr, pin, pin_oe, pin_val, swap, tgt, irq, alarm, live;
  logic [3:0] aoe;
  logic [7:0] gain;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] rs = 32'h7214;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n, k;
  sensor_diag_agc_supervisor #(.OC_DEB_CYC(OCD), .CM_DEB_CYC(CMD),
    .RECOVER_CYC(REC), .DECAY1_CYC(DCY1), .DECAY2_CYC(DCY2),
    .DECAY3_CYC(DCY3), .SWAP0_CYC(SWP[0]), .SWAP1_CYC(SWP[1]),
    .SWAP2_CYC(SWP[2]), .SWAP3_CYC(SWP[3])) DUT (
    .CLOCK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .OC_FAULT_IN(oc), .CM_FAULT_IN(cm), .COIL_OPEN_IN(coil[0]),
    .COIL_SHORT_GND_IN(coil[1]), .COIL_SHORT_VDD_IN(coil[2]),
    .OFFSET_ALARM_IN(coil[3]), .AMP_LOW_IN(low), .AMP_HIGH_IN(high),
    .SUPPLY_5V_IN(s5v), .ALARM_ADDR_SELECT_PIN_IN(pin),
    .ALARM_ADDR_SELECT_PIN_OUT(pin_val),
    .ALARM_ADDR_SELECT_PIN_OE_OUT(pin_oe), .ANALOG_OE_OUT(aoe),
    .SWAP_OUT(swap), .GAIN_OUT(gain), .TARGET_3V0_OUT(tgt), .IRQ_OUT(irq));
  alarm_controller u_ctl (.pull_oe_in(pin_oe), .pull_val_in(pin_val),
    .analog_oe_in(aoe), .pin_level_out(pin), .alarm_out(alarm),
    .live_out(live));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x);
    exp_q.push_back({w, a > 8'h0C, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] probe(input int w);
    return w == 0 ? 8'(aoe) : (w == 1 ? 8'(swap) : gain);
  endfunction
  task automatic wch(input int w, output int c);
    logic [7:0] v;
    v = probe(w);
    c = 0;
    while (probe(w) === v && c < 5000) begin
      @(posedge clk);
      c++;
    end
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", 32'(e[32]), 32'(pslverr));
      if (!e[33]) chk("prdata", e[31:0], prdata);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 5; a++) apb(0, 8'(4 * a), 0, a == 3 ? 32'h220 : 0);
    apb(1, 8'h10, 32'hFF, 0);
    for (int t = 0; t < 2; t++) begin
      // Near-limit pulses with one idle cycle between them must not add up.
      for (int i = 0; i < 6; i++) begin
        n = (t ? CMD : OCD) - 1 - (i < 2 ? 0 : int'(rnd() % 4));
        if (t) cm <= 4'h1 << (rnd() % 4);
        else oc <= 4'h1 << (rnd() % 4);
        repeat (n) @(posedge clk);
        oc <= 4'h0;
        cm <= 4'h0;
        @(posedge clk);
      end
      repeat (6) @(posedge clk);
      chk("oe_kept", 4'hF, 32'(aoe));
      chk("live", 1, 32'(live));
      apb(1, 8'h08, t ? 32'h0 : 32'h1F, 0);
      if (t) cm <= 4'h8;
      else oc <= 4'h2;
      @(posedge clk);
      wch(0, k);
      n = t ? CMD : OCD;
      chk("trip", 1, 32'(k >= n - 1 && k <= n + 6));
      repeat (4) @(posedge clk);
      chk("alarm", 1, 32'(alarm));
      chk("live", 0, 32'(live));
      chk("irq", 32'(!t), 32'(irq));
      oc <= 4'h0;
      cm <= 4'h0;
      wch(0, k);
      chk("off_time", 1, 32'(k + 5 >= REC && k + 3 <= REC));
      apb(0, 8'h04, 0, t ? 32'h12 : 32'h11);
      apb(1, 8'h04, 32'h1F, 0);
      apb(0, 8'h04, 0, 0);
      chk("irq", 0, 32'(irq));
    end
    for (int i = 0; i < 4; i++) begin
      coil <= 4'h1 << i;
      repeat (6) @(posedge clk);
      chk("alarm", 1, 32'(alarm));
      apb(0, 8'h0C, 0, i == 3 ? 32'h20C : 32'h20A);
      coil <= 4'h0;
      repeat (6) @(posedge clk);
      chk("alarm", 0, 32'(alarm));
    end
    apb(0, 8'h04, 0, 32'h0C);
    for (int s = 0; s < 4; s++) begin
      apb(1, 8'h00, 32'(1 + 2 * s), 0);
      wch(1, k);
      wch(1, k);
      chk("swap", SWP[s], k);
    end
    apb(1, 8'h00, 0, 0);
    repeat (12) @(posedge clk);
    chk("swap_off", 0, 32'(swap));
    low <= 1'b1;
    wch(2, k);
    wch(2, k);
    low <= 1'b0;
    chk("step", 2500, k);
    apb(1, 8'h00, 32'h60, 0);
    repeat (5) @(posedge clk);
    chk("gain", 8, 32'(gain));
    chk("target", 0, 32'(tgt));
    s5v <= 1'b1;
    repeat (6) @(posedge clk);
    chk("target", 1, 32'(tgt));
    // A reversal must first sit out the longest decay before stepping down.
    apb(1, 8'h00, 32'h18, 0);
    repeat (3) @(posedge clk);
    high <= 1'b1;
    wch(2, k);
    high <= 1'b0;
    chk("gain_dn", 3, 32'(gain));
    chk("decay", 1, 32'(k >= DCY3));
    final_report();
  end
endmodule
